//--- edm_pkg.sv
`default_nettype none
package edm_pkg;

    // register bus
    localparam int          EDM_ADDR_W       = 4;
    localparam int          EDM_DATA_W       = 16;
    localparam logic [3:0]  EDM_REG_WAIT     = 4'h0;
    localparam logic [3:0]  EDM_REG_CTRL     = 4'h1;
    localparam logic [3:0]  EDM_REG_INDEX    = 4'h2;
    localparam logic [3:0]  EDM_REG_PAGE     = 4'h3;
    localparam logic [3:0]  EDM_REG_IN_LO    = 4'h4;
    localparam logic [3:0]  EDM_REG_IN_HI    = 4'h5;
    localparam logic [3:0]  EDM_REG_OUT_LO   = 4'h6;
    localparam logic [3:0]  EDM_REG_OUT_HI   = 4'h7;
    localparam logic [3:0]  EDM_REG_IN_LEN   = 4'h8;
    localparam logic [3:0]  EDM_REG_OUT_LEN  = 4'h9;
    localparam logic [3:0]  EDM_REG_SETUPHLD = 4'hA;

    // reset values
    localparam logic [15:0] EDM_WAIT_RST     = 16'hFFFF;
    localparam logic [15:0] EDM_SETUPHLD_RST = 16'hFFFF;

    // wait register fields: four regions, 4 bits each
    localparam int          EDM_NUM_REGIONS  = 4;
    localparam int          EDM_WFIELD_W     = 4;

    // control/status bit positions
    localparam int          EDM_CS_IN_PTR    = 7;
    localparam int          EDM_CS_OUT_PTR   = 6;
    localparam int          EDM_CS_IN_CNT    = 5;
    localparam int          EDM_CS_OUT_CNT   = 4;
    localparam int          EDM_CS_WAITPIN   = 3;
    localparam int          EDM_CS_HOLDREQ   = 2;
    localparam int          EDM_CS_STROBE    = 1;
    localparam int          EDM_CS_HOLDACK   = 0;

    // direct access window
    localparam logic [7:0]  EDM_WIN_PAGE     = 8'h3F;
    localparam int          EDM_EXT_AW       = 20;
    localparam int          EDM_IDX_SHIFT    = 12;
    localparam int          EDM_HI_W         = 4;

    typedef enum logic [2:0] {
        EDM_IDLE  = 3'b000,
        EDM_FIX   = 3'b001,
        EDM_WAIT  = 3'b010,
        EDM_DONE  = 3'b011,
        EDM_HELD  = 3'b100
    } edm_state_e;

    typedef struct packed {
        logic [19:0] addr;
        logic [15:0] dataOut;
        logic        dataOe;
        logic        addrOe;
        logic        rdN;
        logic        wrN;
    } edm_bus_s;

endpackage
`default_nettype wire

//--- edm_ctrl.sv
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none
// Operation
// R1 - wait register holds four 4-bit region fields, D..A from top.
// R2 - every wait field resets to fifteen cycles.
// R3 - software never accesses a region whose wait field is zero.
// R4 - software never accesses a region with zero setup or hold.
// R5 - bit 7 loads input start address into input pointer, then clears.
// R6 - bit 6 loads output start address into DMA pointer, then clears.
// R7 - bit 5 loads input line length into input remaining count.
// R8 - bit 4 loads output line length into output remaining count.
// R9 - bit 3 shows wait pin: zero while wait requested.
// R10 - bit 2 shows hold request: one while requested.
// R11 - bit 1 shows strobe: one while an external access runs.
// R12 - bit 0 mirrors the hold-acknowledge pin.
// R13 - window 0x8000-0xFFFF goes external only when data page is 0x3F.
// R14 - external space is 20 address bits by 16-bit words.
// R15 - index register gives upper 8 bits of the external address.
// R16 - external address is window address plus shifted index.
// R17 - X side offset has MSB zero, Y side offset has MSB one.
// R18 - address bits 19..18 select region A, B, C or D.
// R19 - each direct access adds one fixed wait cycle.
// R20 - low wait pin freezes the wait counter and stretches the access.
// R21 - wait counter loads from selected region field at access start.
// R22 - index write is usable by the very next access.
module edm_ctrl
(
    input  wire logic                          clk,
    input  wire logic                          resetn,
    input  wire logic [edm_pkg::EDM_ADDR_W-1:0] regAddr,
    input  wire logic [edm_pkg::EDM_DATA_W-1:0] regWdata,
    input  wire logic                          regWr,
    input  wire logic                          regRd,
    output logic      [edm_pkg::EDM_DATA_W-1:0] regRdata,
    input  wire logic                          coreReq,
    input  wire logic                          coreWe,
    input  wire logic                          coreYSide,
    input  wire logic [15:0]                   coreAddr,
    input  wire logic [15:0]                   coreWdata,
    output logic                               coreStall,
    output logic                               coreDone,
    output logic      [15:0]                   coreRdata,
    output edm_pkg::edm_bus_s                  extBus,
    input  wire logic [15:0]                   extDataIn,
    input  wire logic                          waitPinN,
    input  wire logic                          holdReqPinN,
    output logic                               holdAckPinN,
    output logic                               strobePin,
    output logic      [19:0]                   inAddrPtr,
    output logic      [19:0]                   dmaAddrPtr,
    output logic      [15:0]                   inRemaining,
    output logic      [15:0]                   outRemaining
);
    import edm_pkg::*;

    logic [1:0]  rstSync_r;
    logic        rstN;
    logic [1:0]  waitSync_r;
    logic [1:0]  holdSync_r;
    logic [15:0] dinSync0_r;
    logic [15:0] dinSync1_r;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rstSync_r <= 2'h0;
        else
            rstSync_r <= {rstSync_r[0], 1'b1};
    end
    assign rstN = rstSync_r[1];

    // pin synchronisers
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            waitSync_r <= 2'h3;
            holdSync_r <= 2'h3;
            dinSync0_r <= 16'h0000;
            dinSync1_r <= 16'h0000;
        end
        else
        begin
            waitSync_r <= {waitSync_r[0], waitPinN};
            holdSync_r <= {holdSync_r[0], holdReqPinN};
            dinSync0_r <= extDataIn;
            dinSync1_r <= dinSync0_r;
        end
    end

    // register file
    logic [15:0] waitCyc_r,   waitCyc_nxt;
    logic [15:0] setupHld_r,  setupHld_nxt;
    logic [7:0]  index_r,     index_nxt;
    logic [7:0]  page_r,      page_nxt;
    logic [15:0] inLo_r,      inLo_nxt;
    logic [3:0]  inHi_r,      inHi_nxt;
    logic [15:0] outLo_r,     outLo_nxt;
    logic [3:0]  outHi_r,     outHi_nxt;
    logic [15:0] inLen_r,     inLen_nxt;
    logic [15:0] outLen_r,    outLen_nxt;
    logic [3:0]  loadReq_r,   loadReq_nxt;
    logic [19:0] inPtr_r,     inPtr_nxt;
    logic [19:0] dmaPtr_r,    dmaPtr_nxt;
    logic [15:0] inRem_r,     inRem_nxt;
    logic [15:0] outRem_r,    outRem_nxt;
    logic [15:0] rdata_r,     rdata_nxt;
    logic [7:0]  ctrlStatus;
    logic        accActive;
    logic        held;

    always_comb
    begin
        waitCyc_nxt  = waitCyc_r;
        setupHld_nxt = setupHld_r;
        index_nxt    = index_r;
        page_nxt     = page_r;
        inLo_nxt     = inLo_r;
        inHi_nxt     = inHi_r;
        outLo_nxt    = outLo_r;
        outHi_nxt    = outHi_r;
        inLen_nxt    = inLen_r;
        outLen_nxt   = outLen_r;
        inPtr_nxt    = inPtr_r;
        dmaPtr_nxt   = dmaPtr_r;
        inRem_nxt    = inRem_r;
        outRem_nxt   = outRem_r;
        // R5 R6 R7 R8 pending request: transfer, then clear
        loadReq_nxt  = 4'h0;
        if (loadReq_r[EDM_CS_IN_PTR - EDM_CS_OUT_CNT])
            inPtr_nxt = {inHi_r, inLo_r};
        if (loadReq_r[EDM_CS_OUT_PTR - EDM_CS_OUT_CNT])
            dmaPtr_nxt = {outHi_r, outLo_r};
        if (loadReq_r[EDM_CS_IN_CNT - EDM_CS_OUT_CNT])
            inRem_nxt = inLen_r;
        if (loadReq_r[0])
            outRem_nxt = outLen_r;
        if (regWr)
        begin
            case (regAddr)
                // R1 region wait fields
                EDM_REG_WAIT:     waitCyc_nxt  = regWdata;
                EDM_REG_SETUPHLD: setupHld_nxt = regWdata;
                // R22 index usable next cycle
                EDM_REG_INDEX:    index_nxt    = regWdata[7:0];
                EDM_REG_PAGE:     page_nxt     = regWdata[7:0];
                EDM_REG_IN_LO:    inLo_nxt     = regWdata;
                EDM_REG_IN_HI:    inHi_nxt     = regWdata[EDM_HI_W-1:0];
                EDM_REG_OUT_LO:   outLo_nxt    = regWdata;
                EDM_REG_OUT_HI:   outHi_nxt    = regWdata[EDM_HI_W-1:0];
                EDM_REG_IN_LEN:   inLen_nxt    = regWdata;
                EDM_REG_OUT_LEN:  outLen_nxt   = regWdata;
                // R5 R6 R7 R8 request flags set by writing one
                EDM_REG_CTRL:
                    loadReq_nxt = regWdata[EDM_CS_IN_PTR:EDM_CS_OUT_CNT];
                default:          ;
            endcase
        end
        rdata_nxt = 16'h0000;
        if (regRd)
        begin
            case (regAddr)
                EDM_REG_WAIT:     rdata_nxt = waitCyc_r;
                EDM_REG_SETUPHLD: rdata_nxt = setupHld_r;
                EDM_REG_INDEX:    rdata_nxt = {8'h00, index_r};
                EDM_REG_PAGE:     rdata_nxt = {8'h00, page_r};
                EDM_REG_IN_LO:    rdata_nxt = inLo_r;
                EDM_REG_IN_HI:    rdata_nxt = {12'h000, inHi_r};
                EDM_REG_OUT_LO:   rdata_nxt = outLo_r;
                EDM_REG_OUT_HI:   rdata_nxt = {12'h000, outHi_r};
                EDM_REG_IN_LEN:   rdata_nxt = inLen_r;
                EDM_REG_OUT_LEN:  rdata_nxt = outLen_r;
                EDM_REG_CTRL:     rdata_nxt = {8'h00, ctrlStatus};
                default:          rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            // R2 fifteen waits per region
            waitCyc_r  <= EDM_WAIT_RST;
            setupHld_r <= EDM_SETUPHLD_RST;
            index_r    <= 8'h00;
            page_r     <= 8'h00;
            inLo_r     <= 16'h0000;
            inHi_r     <= 4'h0;
            outLo_r    <= 16'h0000;
            outHi_r    <= 4'h0;
            inLen_r    <= 16'h0000;
            outLen_r   <= 16'h0000;
            loadReq_r  <= 4'h0;
            inPtr_r    <= 20'h00000;
            dmaPtr_r   <= 20'h00000;
            inRem_r    <= 16'h0000;
            outRem_r   <= 16'h0000;
            rdata_r    <= 16'h0000;
        end
        else
        begin
            waitCyc_r  <= waitCyc_nxt;
            setupHld_r <= setupHld_nxt;
            index_r    <= index_nxt;
            page_r     <= page_nxt;
            inLo_r     <= inLo_nxt;
            inHi_r     <= inHi_nxt;
            outLo_r    <= outLo_nxt;
            outHi_r    <= outHi_nxt;
            inLen_r    <= inLen_nxt;
            outLen_r   <= outLen_nxt;
            loadReq_r  <= loadReq_nxt;
            inPtr_r    <= inPtr_nxt;
            dmaPtr_r   <= dmaPtr_nxt;
            inRem_r    <= inRem_nxt;
            outRem_r   <= outRem_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    // direct access address
    logic                winHit;
    logic [15:0]         winOffset;
    logic [EDM_EXT_AW-1:0] extAddrCalc;
    logic [1:0]          region;
    logic [3:0]          regionWait [EDM_NUM_REGIONS];

    // R13 window decode on page 0x3F
    assign winHit    = coreReq && coreAddr[15] && (page_r == EDM_WIN_PAGE);
    // R17 side selects offset MSB
    assign winOffset = {coreYSide, coreAddr[14:0]};
    // R14 R15 R16 index in upper bits plus offset
    assign extAddrCalc = 20'({index_r, 12'h000})
                       + {4'h0, winOffset};
    // R18 region from top two address bits
    assign region    = extAddrCalc[EDM_EXT_AW-1:EDM_EXT_AW-2];

    genvar g;
    generate
        for (g = 0; g < EDM_NUM_REGIONS; g++)
        begin : gRegion
            assign regionWait[g] = waitCyc_r[g*EDM_WFIELD_W +: EDM_WFIELD_W];
        end
    endgenerate

    // access sequencer
    edm_state_e  state_r,   state_nxt;
    logic [3:0]  waitCnt_r, waitCnt_nxt;
    edm_bus_s    bus_r,     bus_nxt;
    logic        we_r,      we_nxt;
    logic        done_r,    done_nxt;
    logic [15:0] crd_r,     crd_nxt;

    always_comb
    begin
        state_nxt   = state_r;
        waitCnt_nxt = waitCnt_r;
        bus_nxt     = bus_r;
        we_nxt      = we_r;
        done_nxt    = 1'b0;
        crd_nxt     = crd_r;
        case (state_r)
            EDM_IDLE:
            begin
                if (!holdSync_r[1])
                begin
                    state_nxt      = EDM_HELD;
                    bus_nxt.addrOe = 1'b0;
                    bus_nxt.dataOe = 1'b0;
                end
                else if (winHit)
                begin
                    state_nxt       = EDM_FIX;
                    // R21 load counter from region field
                    waitCnt_nxt     = regionWait[region];
                    bus_nxt.addr    = extAddrCalc;
                    bus_nxt.dataOut = coreWdata;
                    bus_nxt.dataOe  = coreWe;
                    bus_nxt.addrOe  = 1'b1;
                    bus_nxt.rdN     = coreWe;
                    bus_nxt.wrN     = !coreWe;
                    we_nxt          = coreWe;
                end
            end
            // R19 one fixed wait
            EDM_FIX:
                state_nxt = EDM_WAIT;
            EDM_WAIT:
            begin
                // R20 low wait pin freezes counter
                if (waitSync_r[1])
                begin
                    if (waitCnt_r == 4'h0)
                    begin
                        state_nxt      = EDM_DONE;
                        done_nxt       = 1'b1;
                        bus_nxt.rdN    = 1'b1;
                        bus_nxt.wrN    = 1'b1;
                        bus_nxt.dataOe = 1'b0;
                        if (!we_r)
                            crd_nxt = dinSync1_r;
                    end
                    else
                        waitCnt_nxt = waitCnt_r - 4'h1;
                end
            end
            EDM_DONE:
                state_nxt = EDM_IDLE;
            EDM_HELD:
            begin
                if (holdSync_r[1])
                begin
                    state_nxt      = EDM_IDLE;
                    bus_nxt.addrOe = 1'b1;
                end
            end
            default:
                state_nxt = EDM_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            state_r   <= EDM_IDLE;
            waitCnt_r <= 4'h0;
            bus_r     <= '{addr: 20'h00000, dataOut: 16'h0000,
                           dataOe: 1'b0, addrOe: 1'b1,
                           rdN: 1'b1, wrN: 1'b1};
            we_r      <= 1'b0;
            done_r    <= 1'b0;
            crd_r     <= 16'h0000;
        end
        else
        begin
            state_r   <= state_nxt;
            waitCnt_r <= waitCnt_nxt;
            bus_r     <= bus_nxt;
            we_r      <= we_nxt;
            done_r    <= done_nxt;
            crd_r     <= crd_nxt;
        end
    end

    assign accActive = (state_r == EDM_FIX) || (state_r == EDM_WAIT);
    assign held      = (state_r == EDM_HELD);

    // R9 R10 R11 R12 pin monitors
    assign ctrlStatus = {loadReq_r, waitSync_r[1], !holdSync_r[1],
                         accActive, !held};

    assign regRdata     = rdata_r;
    assign coreStall    = winHit && !done_r;
    assign coreDone     = done_r;
    assign coreRdata    = crd_r;
    assign extBus       = bus_r;
    assign holdAckPinN  = !held;
    assign strobePin    = accActive;
    assign inAddrPtr    = inPtr_r;
    assign dmaAddrPtr   = dmaPtr_r;
    assign inRemaining  = inRem_r;
    assign outRemaining = outRem_r;

endmodule
`default_nettype wire

//--- edm_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module edm_mem_model
(
    input  wire logic              clk,
    input  wire edm_pkg::edm_bus_s extBus,
    input  wire logic [3:0]        stretch,
    output logic      [15:0]       readData,
    output logic                   waitPinN
);
    import edm_pkg::*;
    logic [15:0] mem [logic [19:0]];
    logic [15:0] lastR  = 16'h0000;
    logic [3:0]  lowCnt = 4'h0;
    logic        busy;
    assign busy = extBus.addrOe && !(extBus.rdN && extBus.wrN);
    always @(posedge clk)
    begin
        if (extBus.addrOe && !extBus.wrN)
            mem[extBus.addr] = extBus.dataOut;
        if (busy && !extBus.rdN)
            lastR <= readData;
        lowCnt <= (busy && lowCnt != 4'hF) ? lowCnt + 4'h1 : 4'h0;
    end
    // unwritten words read as address pattern, idle bus inverts
    always @*
        if (busy && !extBus.rdN)
            readData = mem.exists(extBus.addr) ? mem[extBus.addr]
                     : extBus.addr[15:0] ^ 16'h5A5A;
        else
            readData = ~lastR;
    assign waitPinN = !(busy && lowCnt < stretch);
endmodule
`default_nettype wire

//--- edm_ctrl_chk.sv
`timescale 1ns/1ns
`default_nettype none
module edm_ctrl_chk
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [3:0]        regAddr,
    input  wire logic [15:0]       regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    input  wire logic [15:0]       regRdata,
    input  wire logic              coreYSide,
    input  wire logic [15:0]       coreAddr,
    input  wire logic              coreDone,
    input  wire edm_pkg::edm_bus_s extBus,
    input  wire logic              holdAckPinN,
    input  wire logic              strobePin,
    input  wire logic [19:0]       inAddrPtr,
    input  wire logic [19:0]       dmaAddrPtr
);
    import edm_pkg::*;
    logic [7:0]  idxR;
    logic [15:0] waitR;
    logic [5:0]  cntR;
    logic [1:0]  regionR;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            idxR    <= 8'h00;
            waitR   <= EDM_WAIT_RST;
            cntR    <= 6'h00;
            regionR <= 2'h0;
        end
        else
        begin
            if (regWr && regAddr == EDM_REG_INDEX)
                idxR <= regWdata[7:0];
            if (regWr && regAddr == EDM_REG_WAIT)
                waitR <= regWdata;
            cntR <= strobePin ? cntR + 6'h01 : 6'h00;
            if (strobePin && cntR == 6'h00)
                regionR <= extBus.addr[19:18];
        end
    end
    rd_idle_a: assert property (!$past(regRd) |-> regRdata == 16'h0000)
        else $error("read data outside read slot");
    rd_wait_a: assert property (regRd && regAddr == EDM_REG_WAIT
        |=> regRdata == waitR) else $error("wait register readback");
    in_ptr_a: assert property ($changed(inAddrPtr)
        |-> $past(regWr, 2) && $past(regAddr, 2) == EDM_REG_CTRL)
        else $error("input pointer moved without request");
    dma_ptr_a: assert property ($changed(dmaAddrPtr)
        |-> $past(regWr, 2) && $past(regAddr, 2) == EDM_REG_CTRL)
        else $error("dma pointer moved without request");
    strobe_end_a: assert property ($fell(strobePin) |-> coreDone)
        else $error("strobe ended without done");
    hold_rel_a: assert property (!holdAckPinN
        |-> !extBus.addrOe && !strobePin) else $error("bus driven in hold");
    hold_grant_a: assert property ($fell(holdAckPinN)
        |-> !$past(strobePin)) else $error("hold granted mid access");
    fix_wait_a: assert property ($rose(strobePin) |=> strobePin)
        else $error("no fixed wait cycle");
    ext_addr_a: assert property ($rose(strobePin) |-> extBus.addr ==
        {idxR, 12'h000} + {4'h0, coreYSide, coreAddr[14:0]})
        else $error("external address wrong");
    wait_len_a: assert property ($fell(strobePin)
        |-> cntR >= {2'h0, waitR[regionR * 4 +: 4]} + 6'h02)
        else $error("access shorter than wait field");
endmodule
bind edm_ctrl edm_ctrl_chk edm_ctrl_chk_i (.clk(clk), .resetn(resetn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .coreYSide(coreYSide), .coreAddr(coreAddr),
    .coreDone(coreDone), .extBus(extBus), .holdAckPinN(holdAckPinN),
    .strobePin(strobePin), .inAddrPtr(inAddrPtr), .dmaAddrPtr(dmaAddrPtr));
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import edm_pkg::*;
    logic        clk = 1'b0, resetn = 1'b0;
    logic [3:0]  regAddr = 4'h0, stretch = 4'h0;
    logic [15:0] regWdata = 16'h0000, coreAddr = 16'h0000;
    logic [15:0] coreWdata = 16'h0000;
    logic        regWr = 1'b0, regRd = 1'b0, coreReq = 1'b0;
    logic        coreWe = 1'b0, coreYSide = 1'b0, holdReqPinN = 1'b1;
    logic [15:0] regRdata, coreRdata, extDataIn, inRem, outRem;
    logic        coreStall, coreDone, waitPinN, holdAckPinN, strobePin;
    logic [19:0] inAddrPtr, dmaAddrPtr;
    edm_bus_s    extBus;
    int          fail_count = 0;
    int          check_count = 0;
    edm_ctrl edm_ctrl_i (.clk(clk), .resetn(resetn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .coreReq(coreReq), .coreWe(coreWe),
        .coreYSide(coreYSide), .coreAddr(coreAddr), .coreWdata(coreWdata),
        .coreStall(coreStall), .coreDone(coreDone), .coreRdata(coreRdata),
        .extBus(extBus), .extDataIn(extDataIn), .waitPinN(waitPinN),
        .holdReqPinN(holdReqPinN), .holdAckPinN(holdAckPinN),
        .strobePin(strobePin), .inAddrPtr(inAddrPtr),
        .dmaAddrPtr(dmaAddrPtr), .inRemaining(inRem), .outRemaining(outRem));
    edm_mem_model edm_mem_model_i (.clk(clk), .extBus(extBus),
        .stretch(stretch), .readData(extDataIn), .waitPinN(waitPinN));
    always #25 clk = ~clk;
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(string nm, logic [19:0] seen, logic [19:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(string nm, logic [3:0] a, logic [15:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        chk(nm, regRdata, e);
    endtask
    task automatic acc(logic we, logic y, logic [15:0] a, logic [15:0] d,
                       output int lat);
        @(posedge clk);
        coreReq <= 1'b1;
        coreWe <= we;
        coreYSide <= y;
        coreAddr <= a;
        coreWdata <= d;
        @(negedge clk);
        chk("stall", coreStall, 1'b1);
        lat = 1;
        while (coreDone !== 1'b1 && lat < 200)
        begin
            @(negedge clk);
            lat++;
        end
        if (lat >= 200)
        begin
            fail_count++;
            complete_run();
        end
        @(posedge clk);
        coreReq <= 1'b0;
    endtask
    task automatic t_regs();
        rd("waitRst", EDM_REG_WAIT, 16'hFFFF);
        rd("status", EDM_REG_CTRL, 16'h0009);
        wr(EDM_REG_WAIT, 16'h4321); // no zero fields
        rd("wait", EDM_REG_WAIT, 16'h4321);
        wr(EDM_REG_CTRL, 16'h000F);
        rd("statusRo", EDM_REG_CTRL, 16'h0009);
        wr(4'hF, 16'h1234);
        rd("unmapped", 4'hF, 16'h0000);
        $display("regs done");
    endtask
    task automatic t_flags();
        wr(EDM_REG_IN_LO, 16'hBEEF);
        wr(EDM_REG_IN_HI, 16'h000A);
        wr(EDM_REG_OUT_LO, 16'h1234);
        wr(EDM_REG_OUT_HI, 16'h0005);
        wr(EDM_REG_IN_LEN, 16'h0007);
        wr(EDM_REG_OUT_LEN, 16'h0003);
        wr(EDM_REG_CTRL, 16'h00F0);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("inPtr", inAddrPtr, 20'hABEEF);
        chk("dmaPtr", dmaAddrPtr, 20'h51234);
        chk("inRem", inRem, 16'h0007);
        chk("outRem", outRem, 16'h0003);
        rd("flagsClr", EDM_REG_CTRL, 16'h0009);
        $display("flags done");
    endtask
    task automatic t_window();
        logic [7:0]  ix [5] = '{8'h12, 8'h4F, 8'h7F, 8'hC0, 8'hFF};
        logic        ys [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
        logic [15:0] ad [5] = '{16'h8345, 16'h8001, 16'hFFFF, 16'hFFFF,
                                16'hFFFF};
        logic [19:0] ea;
        int          lat;
        wr(EDM_REG_PAGE, 16'h003F);
        for (int i = 0; i < 5; i++)
        begin
            wr(EDM_REG_INDEX, {8'h00, ix[i]});
            acc(1'b0, ys[i], ad[i], 16'h0000, lat);
            ea = {ix[i], 12'h000} + {4'h0, ys[i], ad[i][14:0]};
            chk("lat", lat[19:0], 20'd5 + 20'(ea[19:18]));
            chk("rdata", coreRdata, ea[15:0] ^ 16'h5A5A);
        end
        acc(1'b1, 1'b1, 16'hFFFF, 16'h1357, lat);
        acc(1'b0, 1'b1, 16'hFFFF, 16'h0000, lat);
        chk("wrback", coreRdata, 16'h1357);
        stretch <= 4'h3;
        acc(1'b0, 1'b0, 16'h8345, 16'h0000, lat);
        chk("stretch", 20'(lat > 8), 20'h1);
        stretch <= 4'h0;
        wr(EDM_REG_PAGE, 16'h0000);
        @(posedge clk);
        coreReq <= 1'b1;
        coreAddr <= 16'h8000;
        repeat (3) @(negedge clk);
        chk("noStall", coreStall, 1'b0);
        chk("noStrobe", strobePin, 1'b0);
        @(posedge clk);
        coreReq <= 1'b0;
        $display("window done");
    endtask
    task automatic t_hold();
        @(posedge clk);
        holdReqPinN <= 1'b0;
        repeat (5) @(posedge clk);
        rd("held", EDM_REG_CTRL, 16'h000C);
        chk("addrOe", extBus.addrOe, 1'b0);
        @(posedge clk);
        holdReqPinN <= 1'b1;
        repeat (5) @(posedge clk);
        rd("freed", EDM_REG_CTRL, 16'h0009);
        $display("hold done");
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_flags();
        t_window();
        t_hold();
        complete_run();
    end
endmodule
`default_nettype wire
